// ### hdl/acms_top.sv
// Configuration-mode selection: straps, serial registers, priority and wake-up timing.
// Assumes SYS_CLK_IN is the sampling clock and SER_CLK_IN the host serial clock.
//
// What this block does
// - Data valid at most 100 us after global power down ends.
// - Data valid at most 100 us after the sampling clock restarts.
// - A channel leaving standby gives valid data within 200 clocks.
// - Straps configure the device at power-up without any reset pulse.
// - In strap-only mode the serial pins are static mode straps.
// - Chip-select strap level picks coarse gain and reference source.
// - Clock and data strap levels pick sync, deskew or global power down.
// - A dedicated power-down pin forces global power down.
// - First strap picks one or two lanes and DDR or SDR bit clock.
// - Second strap picks 12x or 14x and the SDR capture edge.
// - Fourth strap picks bit order and data format.
// - In serial modes the three serial pins form the register port.
// - Override bit D10 of register override_control disables strap control.
// - Strap versus register conflicts resolve by a fixed priority.
// - Interface and gain fields rule only while override is high; reference and pattern fields rule always in serial modes.
// - Clock low data high gives sync; both high give deskew.
`timescale 1ns/1ps
`default_nettype none
`include "acms_consts.svh"

module acms_top #(
    parameter int unsigned NUM_CHAN = 4
) (
    // Clocks and reset
    input  wire logic                SYS_CLK_IN,
    input  wire logic                RST_B_IN,
    input  wire logic                SER_CLK_IN,
    // Serial port and strap pins
    input  wire logic                SERIAL_SELECT_GAIN_PIN_IN,
    input  wire logic [1:0]          SERIAL_SELECT_GAIN_LEVEL_IN,
    input  wire logic                SERIAL_DATA_PATTERN_PIN_IN,
    input  wire logic                CHIP_RESET_PIN_IN,
    input  wire logic                POWER_DOWN_PIN_IN,
    input  wire logic [1:0]          INTERFACE_WIDTH_STRAP_IN,
    input  wire logic [1:0]          SERIALIZATION_FACTOR_STRAP_IN,
    input  wire logic [1:0]          BIT_ORDER_FORMAT_STRAP_IN,
    // Sampling clock supervision
    input  wire logic                CLK_RESTART_IN,
    // Output interface setup
    output var  logic                TWO_WIRE_OUT,
    output var  logic                SDR_BIT_CLK_OUT,
    output var  logic                SER_14X_OUT,
    output var  logic                CAPTURE_RISING_OUT,
    output var  logic                LSB_FIRST_OUT,
    output var  logic                OFFSET_BINARY_OUT,
    // Analog setup, patterns and power
    output var  logic                COARSE_GAIN_OUT,
    output var  logic                INTERNAL_REF_OUT,
    output var  logic [1:0]          PATTERN_OUT,
    output var  logic                GLOBAL_PDN_OUT,
    output var  logic [NUM_CHAN-1:0] CHAN_STANDBY_OUT,
    output var  logic [NUM_CHAN-1:0] DATA_VALID_OUT,
    output var  logic                PIN_MODE_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Constants and checks

    localparam int         WakeCyc   = `ACMS_WAKE_TIME_NS / `ACMS_CLK_PERIOD_NS;
    localparam int         StbyCyc   = `ACMS_STBY_WAKE_CYC;
    localparam logic [4:0] FrameBits = 5'(`ACMS_FRAME_BITS);
    localparam int         PinW      = 13;

    generate
        if (NUM_CHAN < 1 || NUM_CHAN > 4) begin : g_bad_chan
            $error("NUM_CHAN must be 1 to 4");
        end
    endgenerate

    // Strap or register codes to interface setup, shared by both sources
    function automatic acms_pkg::acms_cfg_t decode_cfg(input logic [1:0] ifc,
                                                       input logic [1:0] ser,
                                                       input logic [1:0] ord);
        acms_pkg::acms_cfg_t c;
        c.two_wire   = ifc[1];
        c.sdr        = (ifc == 2'h2);
        c.ser14      = ser[1] ^ ser[0];
        c.cap_rise   = ser[1];
        c.lsb_first  = ord[1];
        c.offset_bin = ord[1] ^ ord[0];
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port, link clock domain

    logic        link_clr;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_r;
    logic [15:0] word_r;
    logic        wr_tog_r;

    // Clock stops between frames, so the chip select itself clears the count
    assign link_clr = !RST_B_IN || SERIAL_SELECT_GAIN_PIN_IN;

    always_ff @(posedge SER_CLK_IN or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_cnt_r != FrameBits) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge SER_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            shift_r <= 16'h0000;
        end else if (!SERIAL_SELECT_GAIN_PIN_IN) begin
            shift_r <= {shift_r[14:0], SERIAL_DATA_PATTERN_PIN_IN};
        end
    end

    // Word held stable until the next frame; the toggle carries the event
    always_ff @(posedge SER_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            word_r   <= 16'h0000;
            wr_tog_r <= 1'b0;
        end else if (!SERIAL_SELECT_GAIN_PIN_IN && bit_cnt_r == FrameBits - 5'h01) begin
            word_r   <= {shift_r[14:0], SERIAL_DATA_PATTERN_PIN_IN};
            wr_tog_r <= ~wr_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and crossing synchronisers

    logic [PinW-1:0] pin_meta_r;
    logic [PinW-1:0] pin_sync_r;
    logic            wr_tog_d_r;
    logic            wr_tog_s;
    logic [1:0]      ord_s;
    logic [1:0]      ser_s;
    logic [1:0]      ifc_s;
    logic            pdn_s;
    logic            pin_mode_s;
    logic [1:0]      sen_lvl_s;
    logic [1:0]      pat_strap_s;
    logic            wr_evt;

    // Straps are static, so a plain two-stage vector sync is enough
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {SER_CLK_IN, SERIAL_DATA_PATTERN_PIN_IN,
                           SERIAL_SELECT_GAIN_LEVEL_IN, CHIP_RESET_PIN_IN,
                           POWER_DOWN_PIN_IN, INTERFACE_WIDTH_STRAP_IN,
                           SERIALIZATION_FACTOR_STRAP_IN, BIT_ORDER_FORMAT_STRAP_IN,
                           wr_tog_r};
            pin_sync_r <= pin_meta_r;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wr_tog_d_r <= 1'b0;
        end else begin
            wr_tog_d_r <= wr_tog_s;
        end
    end

    assign wr_tog_s    = pin_sync_r[0];
    assign ord_s       = pin_sync_r[2:1];
    assign ser_s       = pin_sync_r[4:3];
    assign ifc_s       = pin_sync_r[6:5];
    assign pdn_s       = pin_sync_r[7];
    assign pin_mode_s  = pin_sync_r[8];
    assign sen_lvl_s   = pin_sync_r[10:9];
    assign pat_strap_s = pin_sync_r[12:11];
    assign wr_evt      = wr_tog_s ^ wr_tog_d_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [4:0]  wr_addr;
    logic [10:0] wr_data;
    logic        wr_ok;
    logic        reg_clear;
    logic [10:0] ovrd_reg_r;
    logic [10:0] power_reg_r;

    assign wr_addr   = word_r[15:11];
    assign wr_data   = word_r[10:0];
    // Straps own the serial pins in strap-only mode
    assign wr_ok     = wr_evt && !pin_mode_s;
    // Reset pin high or reset bit restores defaults
    assign reg_clear = pin_mode_s ||
                       (wr_ok && wr_addr == `ACMS_REG_RESET_ADDR &&
                        wr_data[`ACMS_RST_BIT]);

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ovrd_reg_r  <= `ACMS_OVRD_RESET;
            power_reg_r <= `ACMS_POWER_RESET;
        end else if (reg_clear) begin
            ovrd_reg_r  <= `ACMS_OVRD_RESET;
            power_reg_r <= `ACMS_POWER_RESET;
        end else if (wr_ok) begin
            if (wr_addr == `ACMS_REG_OVRD_ADDR) begin
                ovrd_reg_r <= wr_data;
            end
            if (wr_addr == `ACMS_REG_POWER_ADDR) begin
                power_reg_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority between straps and registers

    logic                ovrd;
    acms_pkg::acms_cfg_t strap_cfg;
    acms_pkg::acms_cfg_t reg_cfg;
    acms_pkg::acms_cfg_t cfg_nxt;
    logic                gain_nxt;
    logic                ref_nxt;
    logic [1:0]          mode_code;
    logic                pd_nxt;
    logic [1:0]          pat_nxt;
    logic [NUM_CHAN-1:0] stby_nxt;

    assign ovrd      = ovrd_reg_r[`ACMS_OVRD_BIT];
    // Straps decode continuously, so power-up needs no reset pulse
    assign strap_cfg = decode_cfg(ifc_s, ser_s, ord_s);
    assign reg_cfg   = decode_cfg(ovrd_reg_r[`ACMS_IFACE_LSB +: 2],
                                  ovrd_reg_r[`ACMS_SER_LSB +: 2],
                                  ovrd_reg_r[`ACMS_ORDER_LSB +: 2]);
    assign cfg_nxt   = ovrd ? reg_cfg : strap_cfg;

    always_comb begin
        if (pin_mode_s) begin
            gain_nxt  = sen_lvl_s[1] ^ sen_lvl_s[0];
            ref_nxt   = sen_lvl_s[1];
            mode_code = pat_strap_s;
            stby_nxt  = '0;
        end else begin
            // Without override the gain stays at its 0 dB default
            gain_nxt  = ovrd && ovrd_reg_r[`ACMS_GAIN_BIT];
            ref_nxt   = ovrd_reg_r[`ACMS_REF_BIT];
            mode_code = power_reg_r[`ACMS_PAT_LSB +: 2];
            if (power_reg_r[`ACMS_PDN_BIT]) begin
                mode_code = acms_pkg::ACMS_PAT_PDN;
            end
            stby_nxt  = power_reg_r[`ACMS_STBY_LSB +: NUM_CHAN];
        end
        // Power-down pin wins over every other source
        pd_nxt  = pdn_s || (mode_code == acms_pkg::ACMS_PAT_PDN);
        pat_nxt = (mode_code == acms_pkg::ACMS_PAT_PDN) ? acms_pkg::ACMS_PAT_NORMAL
                                                       : mode_code;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            TWO_WIRE_OUT       <= 1'b0;
            SDR_BIT_CLK_OUT    <= 1'b0;
            SER_14X_OUT        <= 1'b0;
            CAPTURE_RISING_OUT <= 1'b0;
            LSB_FIRST_OUT      <= 1'b0;
            OFFSET_BINARY_OUT  <= 1'b0;
            COARSE_GAIN_OUT    <= 1'b0;
            INTERNAL_REF_OUT   <= 1'b0;
            PIN_MODE_OUT       <= 1'b0;
        end else begin
            TWO_WIRE_OUT       <= cfg_nxt.two_wire;
            SDR_BIT_CLK_OUT    <= cfg_nxt.sdr;
            SER_14X_OUT        <= cfg_nxt.ser14;
            CAPTURE_RISING_OUT <= cfg_nxt.cap_rise;
            LSB_FIRST_OUT      <= cfg_nxt.lsb_first;
            OFFSET_BINARY_OUT  <= cfg_nxt.offset_bin;
            COARSE_GAIN_OUT    <= gain_nxt;
            INTERNAL_REF_OUT   <= ref_nxt;
            PIN_MODE_OUT       <= pin_mode_s;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            GLOBAL_PDN_OUT   <= 1'b0;
            PATTERN_OUT      <= acms_pkg::ACMS_PAT_NORMAL;
            CHAN_STANDBY_OUT <= '0;
        end else begin
            GLOBAL_PDN_OUT   <= pd_nxt;
            PATTERN_OUT      <= pat_nxt;
            CHAN_STANDBY_OUT <= stby_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wake-up timing

    logic [NUM_CHAN-1:0] ch_valid;

    acms_wake_if glob_if ();
    acms_wake_if ch_if [NUM_CHAN] ();

    assign glob_if.hold  = GLOBAL_PDN_OUT;
    assign glob_if.start = CLK_RESTART_IN;

    // One cycle of output register latency is taken off the count
    acms_wake_timer #(
        .WAKE_CYC (WakeCyc - 1)
    ) u_glob_timer (
        .clk_in   (SYS_CLK_IN),
        .rst_b_in (RST_B_IN),
        .wk       (glob_if)
    );

    generate
        for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
            assign ch_if[i].hold  = GLOBAL_PDN_OUT || CHAN_STANDBY_OUT[i];
            assign ch_if[i].start = CLK_RESTART_IN;
            assign ch_valid[i]    = ch_if[i].valid;

            acms_wake_timer #(
                .WAKE_CYC (StbyCyc - 1)
            ) u_chan_timer (
                .clk_in   (SYS_CLK_IN),
                .rst_b_in (RST_B_IN),
                .wk       (ch_if[i])
            );
        end
    endgenerate

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            DATA_VALID_OUT <= '0;
        end else begin
            DATA_VALID_OUT <= glob_if.valid ? ch_valid : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [10:0] wait_cnt_r;

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wait_cnt_r <= 11'h000;
        end else if (GLOBAL_PDN_OUT || CLK_RESTART_IN) begin
            wait_cnt_r <= 11'h000;
        end else if (!glob_if.valid && wait_cnt_r != 11'h7FF) begin
            wait_cnt_r <= wait_cnt_r + 11'h001;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    chk_glob_wake_bound: assert property (
        wait_cnt_r < 11'(WakeCyc))
        else $error("global wake-up longer than allowed");

    chk_restart_drops_valid: assert property (
        CLK_RESTART_IN |=> ##1 (DATA_VALID_OUT == '0))
        else $error("data still valid after clock restart");

    chk_chan_wake_time: assert property (
        $fell(CHAN_STANDBY_OUT[0]) |->
        ##[1:StbyCyc] (DATA_VALID_OUT[0] || !glob_if.valid || GLOBAL_PDN_OUT ||
                       CHAN_STANDBY_OUT[0] || CLK_RESTART_IN))
        else $error("channel wake-up longer than allowed");

    chk_pin_mode_writes: assert property (
        pin_mode_s && wr_evt |=> (ovrd_reg_r == `ACMS_OVRD_RESET))
        else $error("serial write accepted in strap-only mode");

    chk_sen_strap_gain: assert property (
        pin_mode_s && sen_lvl_s == 2'h2 |=> COARSE_GAIN_OUT && INTERNAL_REF_OUT)
        else $error("gain strap not applied");

    chk_strap_powerdown: assert property (
        pin_mode_s && pat_strap_s == 2'h2 && !pdn_s |=>
        GLOBAL_PDN_OUT && PATTERN_OUT == acms_pkg::ACMS_PAT_NORMAL)
        else $error("power-down strap not applied");

    chk_pdn_pin_forces: assert property (
        pdn_s |=> GLOBAL_PDN_OUT ##2 (DATA_VALID_OUT == '0))
        else $error("power-down pin not obeyed");

    chk_iface_strap: assert property (
        !ovrd && ifc_s == 2'h2 |=> TWO_WIRE_OUT && SDR_BIT_CLK_OUT)
        else $error("interface strap not applied");

    chk_override_wins: assert property (
        ovrd && ovrd_reg_r[1:0] == 2'h3 && ifc_s != 2'h3 |=>
        TWO_WIRE_OUT && !SDR_BIT_CLK_OUT)
        else $error("override did not take register setting");

    chk_sync_pattern: assert property (
        pin_mode_s && pat_strap_s == 2'h1 |=> PATTERN_OUT == acms_pkg::ACMS_PAT_SYNC)
        else $error("sync strap not applied");

    chk_reset_defaults: assert property (
        pin_mode_s |=> ovrd_reg_r == `ACMS_OVRD_RESET && power_reg_r == `ACMS_POWER_RESET)
        else $error("registers not at defaults under reset pin");

    cov_glob_wake: cover property ($fell(GLOBAL_PDN_OUT) ##[1:WakeCyc] $rose(DATA_VALID_OUT[0]));
    cov_reg_write: cover property (wr_ok && wr_addr == `ACMS_REG_OVRD_ADDR);
    cov_deskew:    cover property (PATTERN_OUT == acms_pkg::ACMS_PAT_DESKEW);
    cov_chan_wake: cover property ($fell(CHAN_STANDBY_OUT[0]) ##[1:StbyCyc] DATA_VALID_OUT[0]);

endmodule

`default_nettype wire

// ### hdl/acms_wake_timer.sv
// Wake-up timer: counts cycles after a hold or restart before data is valid.
// Assumes start and hold are synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

module acms_wake_timer #(
    parameter int unsigned WAKE_CYC = 199
) (
    // Clock and reset
    input  wire logic   clk_in,
    input  wire logic   rst_b_in,
    // Core side
    acms_wake_if.timer  wk
);

    localparam int unsigned   CntW   = $clog2(WAKE_CYC + 1);
    localparam logic [CntW-1:0] CntTop = CntW'(WAKE_CYC);

    logic [CntW-1:0] cnt_r;

    generate
        if (WAKE_CYC < 1) begin : g_bad_cyc
            $error("WAKE_CYC must be at least 1");
        end
    endgenerate

    // Counter saturates; hold or restart sends it back to zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r <= '0;
        end else if (wk.hold || wk.start) begin
            cnt_r <= '0;
        end else if (cnt_r != CntTop) begin
            cnt_r <= cnt_r + CntW'(1);
        end
    end

    assign wk.valid = (cnt_r == CntTop);

    chk_timer_hold_clears: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (wk.hold || wk.start) |=> !wk.valid)
        else $error("timer still valid after hold or restart");

endmodule

`default_nettype wire

// ### pkg/acms_consts.svh
// Offsets, field positions, reset values and timing figures of the mode-select block.
// Included by bare name; holds definitions only.
`ifndef ACMS_CONSTS_SVH
`define ACMS_CONSTS_SVH

// Serial frame: 5 address bits then 11 data bits, first bit first
`define ACMS_ADDR_W         5
`define ACMS_DATA_W         11
`define ACMS_FRAME_BITS     16

// Register addresses
`define ACMS_REG_RESET_ADDR 5'h00
`define ACMS_REG_OVRD_ADDR  5'h0D
`define ACMS_REG_POWER_ADDR 5'h0E

// Register reset register
`define ACMS_RST_BIT        0

// Override control register fields
`define ACMS_IFACE_LSB      0
`define ACMS_SER_LSB        2
`define ACMS_ORDER_LSB      4
`define ACMS_GAIN_BIT       6
`define ACMS_REF_BIT        7
`define ACMS_OVRD_BIT       10

// Power and pattern register fields
`define ACMS_PAT_LSB        0
`define ACMS_PDN_BIT        2
`define ACMS_STBY_LSB       3

// Reset values
`define ACMS_OVRD_RESET     11'h000
`define ACMS_POWER_RESET    11'h000

// Wake-up timing
`define ACMS_WAKE_TIME_NS   100000
`define ACMS_CLK_PERIOD_NS  100
`define ACMS_STBY_WAKE_CYC  200

`endif

// ### pkg/acms_pkg.sv
// Types shared by the mode-select block.
// Assumes nothing of its surroundings.
package acms_pkg;

    // Two-bit mode code of the clock/data straps and of the pattern field
    typedef enum logic [1:0] {
        ACMS_PAT_NORMAL = 2'h0,
        ACMS_PAT_SYNC   = 2'h1,
        ACMS_PAT_PDN    = 2'h2,
        ACMS_PAT_DESKEW = 2'h3
    } acms_pat_t;

    // Output interface setup decoded from straps or registers
    typedef struct packed {
        logic two_wire;
        logic sdr;
        logic ser14;
        logic cap_rise;
        logic lsb_first;
        logic offset_bin;
    } acms_cfg_t;

endpackage

// ### pkg/acms_wake_if.sv
// Handshake between the mode-select core and one wake-up timer.
// Assumes all signals are on the sampling clock.
`timescale 1ns/1ps
`default_nettype none

interface acms_wake_if;
    logic start;
    logic hold;
    logic valid;

    modport timer (input start, input hold, output valid);
    modport ctrl  (output start, output hold, input valid);
endinterface

`default_nettype wire

// ### verif/acms_host_model.sv
// Host model: serial frames on the link clock, static levels between frames.
// Assumes link_clk_in runs free; it is gated off outside frames.
`timescale 1ns/1ps
`default_nettype none

module acms_host_model (
    // Link clock and request
    input  wire logic        link_clk_in,
    input  wire logic        start_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [10:0] data_in,
    // Levels shown between frames
    input  wire logic        idle_clk_in,
    input  wire logic        idle_dat_in,
    // Pins
    output logic             ser_clk_out,
    output logic             select_b_out,
    output logic             data_out,
    output var logic         busy_out
);
    logic [15:0] sh_r  = 16'h0000;
    logic [4:0]  cnt_r = 5'h00;
    logic        bit_r = 1'b0;
    logic        busy_r = 1'b0;

    assign busy_out     = busy_r;
    // Clock stands at the strap level between frames
    assign ser_clk_out  = (busy_r && cnt_r != 5'h00) ? link_clk_in : idle_clk_in;
    assign select_b_out = ~busy_r;
    assign data_out     = busy_r ? bit_r : idle_dat_in;

    // Bits change on the falling edge, device samples on the rising one
    always @(negedge link_clk_in) begin
        if (!busy_r) begin
            if (start_in) begin
                sh_r   <= {addr_in, data_in};
                cnt_r  <= 5'h00;
                busy_r <= 1'b1;
            end
        end else if (cnt_r == 5'h10) begin
            busy_r <= 1'b0;
        end else begin
            bit_r <= sh_r[15];
            sh_r  <= sh_r << 1;
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule

`default_nettype wire

// ### verif/acms_top_tb.sv
// Testbench: strap decoding, serial override, priority and wake-up timing.
// Assumes acms_host_model stands in for the host controller.
`timescale 1ns/1ps
`default_nettype none

module acms_top_tb;
    logic clk = 1'b0, lclk = 1'b0, rst_b, creset, pdn, restart, go, idle_c, idle_d;
    logic [1:0] lvl, ifc, ser, ord, pat;
    logic [4:0] addr;
    logic [10:0] data;
    logic sclk, sel_b, sdat, busy, two, sdr, s14, rise, lsb, off, gain, iref, gpd, pmode;
    logic [3:0] stby, vld;
    int err_count, comparisons, n;
    logic [1:0] e_if[4] = '{2'h0, 2'h0, 2'h3, 2'h2};
    logic [1:0] e_sr[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [1:0] e_or[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [1:0] e_gr[4] = '{2'h0, 2'h2, 2'h3, 2'h1};

    always #50 clk = ~clk;
    // Link clock phase unrelated to the sampling clock
    initial begin
        #7;
        forever #15 lclk = ~lclk;
    end

    acms_host_model host (.link_clk_in(lclk), .start_in(go), .addr_in(addr), .data_in(data),
        .idle_clk_in(idle_c), .idle_dat_in(idle_d), .ser_clk_out(sclk),
        .select_b_out(sel_b), .data_out(sdat), .busy_out(busy));

    // Reserved strap has no port: the board grounds it
    acms_top dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .SER_CLK_IN(sclk),
        .SERIAL_SELECT_GAIN_PIN_IN(sel_b), .SERIAL_SELECT_GAIN_LEVEL_IN(lvl),
        .SERIAL_DATA_PATTERN_PIN_IN(sdat), .CHIP_RESET_PIN_IN(creset),
        .POWER_DOWN_PIN_IN(pdn), .INTERFACE_WIDTH_STRAP_IN(ifc),
        .SERIALIZATION_FACTOR_STRAP_IN(ser), .BIT_ORDER_FORMAT_STRAP_IN(ord),
        .CLK_RESTART_IN(restart), .TWO_WIRE_OUT(two), .SDR_BIT_CLK_OUT(sdr),
        .SER_14X_OUT(s14), .CAPTURE_RISING_OUT(rise), .LSB_FIRST_OUT(lsb),
        .OFFSET_BINARY_OUT(off), .COARSE_GAIN_OUT(gain), .INTERNAL_REF_OUT(iref),
        .PATTERN_OUT(pat), .GLOBAL_PDN_OUT(gpd), .CHAN_STANDBY_OUT(stby),
        .DATA_VALID_OUT(vld), .PIN_MODE_OUT(pmode));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Checks happen mid-cycle, clear of the edge updates
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wake(input int lim);
        n = 0;
        while (vld[0] !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                chk("wake timeout", 1, 0);
                end_of_test();
            end
        end
    endtask

    // Gap first keeps frames over 2 us apart
    task automatic wr(input logic [4:0] a, input logic [10:0] d);
        int i;
        repeat (22) @(posedge clk);
        addr <= a;
        data <= d;
        go   <= 1'b1;
        for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
        // Count stays 0 only if the frame never started
        if (busy !== 1'b0 || i == 0) begin
            chk("frame timeout", 1, 0);
            end_of_test();
        end
        settle(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {go, idle_c, idle_d, pdn, restart, lvl, ifc, ser, ord, addr, data} = '0;
        rst_b = 1'b0;
        creset = 1'b1;
        err_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            {lvl, ifc, ser, ord} <= {4{c[1:0]}};
            settle(6);
            chk("pin mode", pmode, 1);
            chk("iface", {two, sdr}, e_if[c]);
            chk("serial", {s14, rise}, e_sr[c]);
            chk("order", {lsb, off}, e_or[c]);
            chk("gain ref", {gain, iref}, e_gr[c]);
        end
        // A frame in strap-only mode must leave the strap setup alone
        wr(5'h0D, 11'h4DB);
        chk("strap only write", {two, sdr, s14, rise, lsb, off, gain, iref}, 8'h99);
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            {idle_c, idle_d} <= p[1:0];
            settle(6);
            chk("pattern", pat, (p == 2) ? 0 : p);
            chk("pdn", gpd, p == 2);
        end
        @(posedge clk);
        {idle_c, idle_d} <= 2'h0;
        pdn <= 1'b1;
        settle(6);
        chk("pdn pin", {gpd, vld[0]}, 2'h2);
        @(posedge clk);
        pdn <= 1'b0;
        wake(1010);
        chk("wake pdn", n inside {[990:1004]}, 1);
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        settle(3);
        chk("restart drop", vld[0], 0);
        wake(1010);
        chk("wake restart", n inside {[990:1002]}, 1);
        chk("valid all", vld, 4'hF);
        @(posedge clk);
        creset <= 1'b0;
        {lvl, ifc, ser, ord} <= '0;
        settle(6);
        chk("serial mode", pmode, 0);
        wr(5'h00, 11'h001);
        wr(5'h0D, 11'h4DB);
        chk("override", {two, sdr, s14, rise, lsb, off, gain, iref}, 8'hB7);
        wr(5'h0D, 11'h0DB);
        chk("straps", {two, sdr, s14, rise, lsb, off, gain, iref}, 8'h01);
        wr(5'h1F, 11'h7FF);
        chk("unmapped", {two, sdr, s14, rise, lsb, off, gain, iref}, 8'h01);
        wr(5'h0E, 11'h001);
        chk("pattern reg", {pat, gpd}, 3'h2);
        wr(5'h0E, 11'h008);
        chk("standby", {stby, vld}, 8'h1E);
        wr(5'h0E, 11'h000);
        wake(300);
        chk("wake standby", n inside {[190:200]}, 1);
        wr(5'h0E, 11'h004);
        chk("pdn reg", {pat, gpd, vld[0]}, 4'h2);
        end_of_test();
    end
endmodule

`default_nettype wire
